/* File: edac_ctrl.v */
// Controller that sequences an external 32-bit SEC-DED correction unit through its pins.
`include "edac_map.vh"

////////////////////////////////////////////////////////////////////////////////
module edac_ctrl (
	// Clock and reset.
	input  wire        clk_sys_i,
	input  wire        sys_rst_i,
	// User command port.
	input  wire        cmd_valid_i,
	input  wire [1:0]  cmd_op_i,
	input  wire [31:0] cmd_data_i,
	input  wire [6:0]  cmd_check_i,
	input  wire [3:0]  cmd_byte_mask_i,
	output reg         cmd_ready_o,
	output reg         rsp_valid_o,
	output reg  [31:0] rsp_data_o,
	output reg  [6:0]  rsp_check_o,
	output reg         rsp_single_err_o,
	output reg         rsp_multi_err_o,
	// Device mode selects and latch enable.
	output reg         mode_select_low_o,
	output reg         mode_select_high_o,
	output reg         output_latch_enable_n_o,
	// Device data port, three signals per pin.
	input  wire [31:0] data_port_i,
	output reg  [31:0] data_port_o,
	output reg  [31:0] data_port_oe_o,
	output reg  [3:0]  byte_output_enable_n_o,
	// Device check port, in and out per pin, one enable for the whole port.
	input  wire [6:0]  check_port_i,
	output reg  [6:0]  check_port_o,
	output reg         check_port_oe_o,
	output reg         check_output_enable_n_o,
	// Device error flags.
	input  wire        single_error_flag_n_i,
	input  wire        multi_error_flag_n_i
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_SETUP = 3'h1;
	localparam ST_HOLD  = 3'h2;
	localparam ST_CORR  = 3'h3;
	localparam ST_MOD   = 3'h4;
	localparam ST_GEN   = 3'h5;
	localparam ST_DONE  = 3'h6;

	// Cycle counts are worked out at integer width, then cut to the counter width.
	localparam integer SETUP_CYC_I = `EDAC_SETUP_CYC;
	localparam integer HOLD_CYC_I  = `EDAC_HOLD_CYC;
	localparam integer CORR_CYC_I  = `EDAC_CORR_CYC;
	localparam integer LATCH_CYC_I = `EDAC_LATCH_CYC;
	localparam integer CHECK_CYC_I = `EDAC_CHECK_CYC;
	localparam [7:0]   SETUP_CYC   = SETUP_CYC_I[7:0];
	localparam [7:0]   HOLD_CYC    = HOLD_CYC_I[7:0];
	localparam [7:0]   CORR_CYC    = CORR_CYC_I[7:0];
	localparam [7:0]   LATCH_CYC   = LATCH_CYC_I[7:0];
	localparam [7:0]   CHECK_CYC   = CHECK_CYC_I[7:0];

	reg [2:0]  state;
	reg [7:0]  cnt;
	reg [1:0]  op;
	reg [31:0] wdata;
	reg [6:0]  wcheck;
	reg [3:0]  mask;

	wire [31:0] s_data;
	wire [6:0]  s_check;
	wire [1:0]  s_flag_n;

	////////////////////////////////////////////////////////////////////////////
	// Device pins cross into the system clock through two flip-flops.
	edac_sync #(.W(32)) u_sync_data (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (data_port_i),
		.sync_o    (s_data)
	);
	edac_sync #(.W(7)) u_sync_check (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (check_port_i),
		.sync_o    (s_check)
	);
	edac_sync #(.W(2)) u_sync_flag (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({multi_error_flag_n_i, single_error_flag_n_i}),
		.sync_o    (s_flag_n)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer. The correction, latch and check-word counts add two cycles for the input synchroniser; setup and hold do not.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state                   <= ST_IDLE;
			cnt                     <= 8'h00;
			op                      <= 2'h0;
			wdata                   <= 32'h00000000;
			wcheck                  <= 7'h00;
			mask                    <= 4'h0;
			cmd_ready_o             <= 1'b0;
			rsp_valid_o             <= 1'b0;
			rsp_data_o              <= 32'h00000000;
			rsp_check_o             <= 7'h00;
			rsp_single_err_o        <= 1'b0;
			rsp_multi_err_o         <= 1'b0;
			mode_select_low_o       <= 1'b0;
			mode_select_high_o      <= 1'b1;
			output_latch_enable_n_o <= 1'b0;
			data_port_o             <= 32'h00000000;
			data_port_oe_o          <= 32'h00000000;
			byte_output_enable_n_o  <= 4'hF;
			check_port_o            <= 7'h00;
			check_port_oe_o         <= 1'b0;
			check_output_enable_n_o <= 1'b1;
		end else begin
			rsp_valid_o <= 1'b0;
			case (state)
			ST_IDLE: begin
				cmd_ready_o <= 1'b1;
				if (cmd_valid_i && cmd_ready_o) begin
					cmd_ready_o             <= 1'b0;
					op                      <= cmd_op_i;
					wdata                   <= cmd_data_i;
					wcheck                  <= cmd_check_i;
					mask                    <= cmd_byte_mask_i;
					cnt                     <= 8'h00;
					output_latch_enable_n_o <= 1'b0;
					data_port_o             <= cmd_data_i;
					data_port_oe_o          <= 32'hFFFFFFFF;
					byte_output_enable_n_o  <= 4'hF;
					if (cmd_op_i == `EDAC_CMD_WRITE) begin
						// Write mode: device makes the check word and drives it.
						mode_select_low_o       <= 1'b0;
						mode_select_high_o      <= 1'b0;
						check_port_oe_o         <= 1'b0;
						check_output_enable_n_o <= 1'b0;
						state                   <= ST_GEN;
					end else begin
						// Read mode: present data and stored check word.
						mode_select_low_o       <= 1'b0;
						mode_select_high_o      <= 1'b1;
						check_port_o            <= cmd_check_i;
						check_port_oe_o         <= 1'b1;
						check_output_enable_n_o <= 1'b1;
						state                   <= ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				cnt <= cnt + 8'h01;
				if (cnt + 8'h01 >= SETUP_CYC) begin
					cnt               <= 8'h00;
					mode_select_low_o <= 1'b1;
					// Diagnostic entry drops the high select low.
					if (op == `EDAC_CMD_DIAG)
						mode_select_high_o <= 1'b0;
					state <= ST_HOLD;
				end
			end
			ST_HOLD: begin
				cnt <= cnt + 8'h01;
				if (cnt + 8'h01 >= HOLD_CYC) begin
					// The correction count starts from zero, or the latch would rise too early.
					cnt             <= 8'h00;
					// Release our drivers on the same edge that the device is enabled to drive back.
					data_port_oe_o  <= 32'h00000000;
					check_port_oe_o <= 1'b0;
					if (op == `EDAC_CMD_DIAG) begin
						// Latched check word is read back; data stays transparent.
						check_output_enable_n_o <= 1'b0;
						byte_output_enable_n_o  <= 4'hF;
						data_port_o             <= wdata;
						data_port_oe_o          <= 32'hFFFFFFFF;
					end else begin
						byte_output_enable_n_o  <= 4'h0;
						check_output_enable_n_o <= 1'b0;
					end
					state <= ST_CORR;
				end
			end
			ST_CORR: begin
				cnt <= cnt + 8'h01;
				// Latch enable rises only after the latch wait from low select.
				if (cnt + HOLD_CYC + 8'h01 >= LATCH_CYC + 8'h02)
					output_latch_enable_n_o <= 1'b1;
				if (cnt + 8'h01 >= CORR_CYC + 8'h02 && cnt + HOLD_CYC + 8'h01 >= LATCH_CYC + 8'h02) begin
					// Corrected data and flags are valid here.
					cnt              <= 8'h00;
					rsp_data_o       <= s_data;
					rsp_check_o      <= s_check;
					rsp_single_err_o <= ~s_flag_n[0];
					rsp_multi_err_o  <= ~s_flag_n[1];
					output_latch_enable_n_o <= 1'b1;
					if (op == `EDAC_CMD_RMW) begin
						// Masked lanes are driven by us, the rest by the latch.
						byte_output_enable_n_o <= mask;
						data_port_o            <= wdata;
						data_port_oe_o         <= {{8{mask[3]}}, {8{mask[2]}}, {8{mask[1]}}, {8{mask[0]}}};
						check_output_enable_n_o <= 1'b1;
						state                  <= ST_MOD;
					end else if (op == `EDAC_CMD_DIAG) begin
						// Raise the high select with the latch transparent.
						mode_select_high_o      <= 1'b1;
						output_latch_enable_n_o <= 1'b0;
						data_port_oe_o          <= 32'h00000000;
						byte_output_enable_n_o  <= 4'h0;
						op                      <= `EDAC_CMD_READ;
					end else begin
						state <= ST_DONE;
					end
				end
			end
			ST_MOD: begin
				// Latch enable already high, so both selects may drop now.
				if (output_latch_enable_n_o) begin
					mode_select_low_o       <= 1'b0;
					mode_select_high_o      <= 1'b0;
					check_output_enable_n_o <= 1'b0;
					state                   <= ST_GEN;
				end
			end
			ST_GEN: begin
				cnt <= cnt + 8'h01;
				if (cnt + 8'h01 >= CHECK_CYC + 8'h02) begin
					cnt         <= 8'h00;
					rsp_check_o <= s_check;
					rsp_data_o  <= (op == `EDAC_CMD_RMW) ? s_data : wdata;
					state       <= ST_DONE;
				end
			end
			ST_DONE: begin
				// Return pins to an idle read mode with everything released.
				rsp_valid_o             <= 1'b1;
				data_port_oe_o          <= 32'h00000000;
				check_port_oe_o         <= 1'b0;
				byte_output_enable_n_o  <= 4'hF;
				check_output_enable_n_o <= 1'b1;
				mode_select_low_o       <= 1'b0;
				mode_select_high_o      <= 1'b1;
				output_latch_enable_n_o <= 1'b0;
				state                   <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // edac_ctrl

/* File: edac_map.vh */
// Constants shared by the error-correction unit controller.
`ifndef EDAC_MAP_VH
`define EDAC_MAP_VH
// Mode select encodings {high, low}.
`define EDAC_MODE_WRITE 2'h0
`define EDAC_MODE_DIAG  2'h1
`define EDAC_MODE_READ  2'h2
`define EDAC_MODE_CORR  2'h3
// Timing figures in ns.
`define EDAC_CLK_NS     4
`define EDAC_SETUP_NS   10
`define EDAC_HOLD_NS    15
`define EDAC_CORR_NS    58
`define EDAC_LATCH_NS   45
`define EDAC_CHECK_NS   48
// Cycle counts: least times round up, waits for valid data round up as well.
`define EDAC_SETUP_CYC  ((`EDAC_SETUP_NS + `EDAC_CLK_NS - 1) / `EDAC_CLK_NS)
`define EDAC_HOLD_CYC   ((`EDAC_HOLD_NS + `EDAC_CLK_NS - 1) / `EDAC_CLK_NS)
`define EDAC_CORR_CYC   ((`EDAC_CORR_NS + `EDAC_CLK_NS - 1) / `EDAC_CLK_NS)
`define EDAC_LATCH_CYC  ((`EDAC_LATCH_NS + `EDAC_CLK_NS - 1) / `EDAC_CLK_NS)
`define EDAC_CHECK_CYC  ((`EDAC_CHECK_NS + `EDAC_CLK_NS - 1) / `EDAC_CLK_NS)
// Command codes on the user port.
`define EDAC_CMD_WRITE  2'h0
`define EDAC_CMD_READ   2'h1
`define EDAC_CMD_RMW    2'h2
`define EDAC_CMD_DIAG   2'h3
`endif

/* File: edac_sync.v */
// Two flip-flop synchroniser for device pin inputs.
module edac_sync #(
	parameter W = 1
) (
	// Clock and reset.
	input  wire         clk_sys_i,
	input  wire         sys_rst_i,
	// Asynchronous input and synchronised output.
	input  wire [W-1:0] async_i,
	output reg  [W-1:0] sync_o
);
	reg [W-1:0] meta;

	// The first stage feeds only the second stage.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta   <= {W{1'b0}};
			sync_o <= {W{1'b0}};
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule // edac_sync

/* File: edac_dev_model.sv */
// Behavioural model of the external correction unit.
module edac_dev #(
	parameter DLY = 0
) (
	// Selects {high, low} and latch enable.
	input  wire [1:0]  sel_i,
	input  wire        lat_n_i,
	// Bus levels in, drive values and flags out.
	input  wire [31:0] dat_i,
	input  wire [6:0]  chk_i,
	output wire [31:0] dat_o,
	output wire [6:0]  chk_o,
	output wire        single_n_o,
	output wire        multi_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	reg  [31:0] din, dout, fixd;
	reg  [6:0]  cin;
	wire [6:0]  syn = gen(din) ^ cin;
	integer     i;
	////////////////////////
	// Bit b owns the b-th weight-three column, so an odd syndrome names one bit.
	function automatic [6:0] col(input integer b);
		integer v;
		integer k;
		k = -1;
		col = 7'h00;
		for (v = 0; v < 128; v = v + 1)
			if ($countones(v[6:0]) == 3 && k < b) begin
				k = k + 1;
				col = v[6:0];
			end
	endfunction
	function automatic [6:0] gen(input [31:0] d);
		integer j;
		gen = 7'h00;
		for (j = 0; j < 32; j = j + 1)
			if (d[j])
				gen = gen ^ col(j);
	endfunction
	// Input latches: check held from the low select rise, data only in correct mode.
	always @* begin
		if (!sel_i[0])
			cin = chk_i;
		if (sel_i != 2'h3)
			din = dat_i;
	end
	// Correction in correct mode only, then the transparent output latch.
	always @* begin
		fixd = din;
		for (i = 0; i < 32; i = i + 1)
			if (sel_i == 2'h3 && col(i) == syn)
				fixd[i] = ~fixd[i];
		if (!lat_n_i)
			dout = fixd;
	end
	// Outputs settle after DLY, kept inside the 48 ns and 58 ns limits.
	assign #DLY dat_o = dout;
	assign #DLY chk_o = (sel_i == 2'h0) ? gen(din) : ((sel_i == 2'h1) ? cin : syn);
	assign #DLY single_n_o = !(sel_i != 2'h0 && syn != 7'h00);
	assign #DLY multi_n_o = !(sel_i != 2'h0 && syn != 7'h00 && !(^syn));
endmodule // edac_dev

/* File: edac_ctrl_asserts.sv */
// Assertions on the controller's pins and handshake.
module edac_ctrl_chk (
	// Clock and reset.
	input wire        clk_sys_i,
	input wire        sys_rst_i,
	// User side.
	input wire        cmd_valid_i,
	input wire        cmd_ready_o,
	input wire        rsp_valid_o,
	input wire        rsp_single_err_o,
	input wire        rsp_multi_err_o,
	// Device pins.
	input wire        mode_select_low_o,
	input wire        mode_select_high_o,
	input wire        output_latch_enable_n_o,
	input wire [31:0] data_port_o,
	input wire [31:0] data_port_oe_o,
	input wire [3:0]  byte_output_enable_n_o,
	input wire        check_port_oe_o,
	input wire        check_output_enable_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	reg  [7:0]  age;
	wire [3:0]  be = byte_output_enable_n_o;
	wire [31:0] lane = ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////
	// Cycles since the low select rose, saturating.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i || !mode_select_low_o)
			age <= 8'h00;
		else if (age != 8'hFF)
			age <= age + 8'h01;
	end
	// Bus ownership, hold windows, latch timing and handshake.
	chk_lane_clash:
		assert property (!(|(data_port_oe_o & lane))) else $error("lane clash");
	chk_check_clash:
		assert property (!(check_port_oe_o && !check_output_enable_n_o)) else $error("check clash");
	chk_latch_wait:
		assert property ($rose(output_latch_enable_n_o) && mode_select_low_o |-> age >= 8'h0C) else $error("early latch");
	chk_latch_held:
		assert property (!mode_select_low_o && !mode_select_high_o && !(&be) |-> output_latch_enable_n_o) else $error("latch open");
	chk_data_setup:
		assert property ($rose(mode_select_low_o) |-> $past(&data_port_oe_o, 3) && $past(data_port_o, 3) == data_port_o)
			else $error("short setup");
	chk_data_hold:
		assert property ($rose(mode_select_low_o) |-> (&data_port_oe_o && check_port_oe_o) [*4]) else $error("short hold");
	chk_flag_order:
		assert property (rsp_valid_o && rsp_multi_err_o |-> rsp_single_err_o) else $error("flag order");
	chk_cmd_answer:
		assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o ##[1:200] rsp_valid_o) else $error("no answer");
	// Main scenarios reached.
	cover property ($rose(output_latch_enable_n_o));
	cover property (rsp_valid_o && rsp_multi_err_o);
	cover property (mode_select_low_o && !mode_select_high_o);
endmodule // edac_ctrl_chk
bind edac_ctrl edac_ctrl_chk i_chk (.*);

/* File: tb_top.sv */
// Self-checking bench for the correction unit controller.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	reg         clk_sys_i, sys_rst_i, cmd_valid_i;
	reg  [1:0]  cmd_op_i;
	reg  [3:0]  cmd_byte_mask_i;
	reg  [6:0]  cmd_check_i;
	reg  [31:0] cmd_data_i, w;
	wire        cmd_ready_o, rsp_valid_o, rsp_single_err_o, rsp_multi_err_o, single_error_flag_n_i;
	wire        mode_select_low_o, mode_select_high_o, output_latch_enable_n_o, multi_error_flag_n_i;
	wire        check_port_oe_o, check_output_enable_n_o;
	wire [3:0]  byte_output_enable_n_o;
	wire [6:0]  rsp_check_o, check_port_i, check_port_o, dev_chk;
	wire [31:0] rsp_data_o, data_port_i, data_port_o, data_port_oe_o, dev_dat;
	wire [3:0]  be = byte_output_enable_n_o;
	wire [31:0] lane = ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	integer     n_errors, num_checks, cyc, i;
	reg  [6:0]  diag_chk;
	reg  [1:0]  diag_flg;
	////////////////////////
	edac_ctrl i_dut (.*);
	edac_dev #(.DLY(20)) i_dev (
		.sel_i({mode_select_high_o, mode_select_low_o}),
		.lat_n_i(output_latch_enable_n_o),
		.dat_i(data_port_i),
		.chk_i(check_port_i),
		.dat_o(dev_dat),
		.chk_o(dev_chk),
		.single_n_o(single_error_flag_n_i),
		.multi_n_o(multi_error_flag_n_i)
	);
	// Wire levels; a released line shows the inverse of our last drive.
	assign data_port_i = (lane & dev_dat) | (~lane & (data_port_o ^ ~data_port_oe_o));
	assign check_port_i = !check_output_enable_n_o ? dev_chk : (check_port_o ^ {7{~check_port_oe_o}});
	// Keeps the last check word and flags seen while the latched word is read back in diagnostic mode.
	always @(posedge clk_sys_i) begin
		if (mode_select_low_o && !mode_select_high_o && !check_output_enable_n_o) begin
			diag_chk <= check_port_i;
			diag_flg <= {~single_error_flag_n_i, ~multi_error_flag_n_i};
		end
	end
	// Clock and hang limit.
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			n_errors = n_errors + 1;
			give_verdict;
		end
	end
	// Compares one value and counts it.
	task check_val(input string what, input [31:0] exp, input [31:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Issues one command once ready and waits for its answer pulse.
	task run(input [1:0] op, input [31:0] dat, input [6:0] chk, input [3:0] msk);
		@(posedge clk_sys_i);
		while (cmd_ready_o !== 1'b1)
			@(posedge clk_sys_i);
		cmd_valid_i <= 1'b1;
		cmd_op_i <= op;
		cmd_data_i <= dat;
		cmd_check_i <= chk;
		cmd_byte_mask_i <= msk;
		@(posedge clk_sys_i);
		cmd_valid_i <= 1'b0;
		while (rsp_valid_o !== 1'b1)
			@(posedge clk_sys_i);
	endtask
	// Reads one stored word and checks data, syndrome and flags.
	task rd(input [31:0] dat, input [6:0] chk, input [31:0] exp, input [1:0] flg);
		run(2'h1, dat, chk, 4'h0);
		check_val("data", exp, rsp_data_o);
		check_val("syndrome", {25'h0, i_dev.gen(dat) ^ chk}, {25'h0, rsp_check_o});
		check_val("flags", {30'h0, flg}, {30'h0, rsp_single_err_o, rsp_multi_err_o});
	endtask
	// Prints the counts and the verdict, then stops.
	task give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Write, reads with clean, single, check-bit and double errors, byte writes, diagnostics.
	initial begin
		n_errors = 0;
		num_checks = 0;
		cyc = 0;
		sys_rst_i = 1'b1;
		cmd_valid_i = 1'b0;
		cmd_op_i = 2'h0;
		cmd_data_i = 32'h0;
		cmd_check_i = 7'h00;
		cmd_byte_mask_i = 4'h0;
		w = 32'hA5C30F17;
		repeat (4) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		run(2'h0, w, 7'h00, 4'h0);
		check_val("write check", {25'h0, i_dev.gen(w)}, {25'h0, rsp_check_o});
		rd(w, i_dev.gen(w), w, 2'h0);
		for (i = 0; i < 32; i = i + 5)
			rd(w ^ (32'h1 << i), i_dev.gen(w), w, 2'h2);
		rd(w, i_dev.gen(w) ^ 7'h10, w, 2'h2);
		rd(w ^ 32'h3, i_dev.gen(w), w ^ 32'h3, 2'h3);
		run(2'h2, w ^ 32'h8, i_dev.gen(w), 4'h1);
		check_val("merged", w ^ 32'h8, rsp_data_o);
		check_val("new check", {25'h0, i_dev.gen(w ^ 32'h8)}, {25'h0, rsp_check_o});
		run(2'h2, w ^ 32'h08000000, i_dev.gen(w), 4'h6);
		check_val("merged", w, rsp_data_o);
		run(2'h3, w ^ 32'h800, i_dev.gen(w), 4'h0);
		check_val("diag data", w, rsp_data_o);
		check_val("diag flags", 32'h2, {30'h0, rsp_single_err_o, rsp_multi_err_o});
		check_val("diag check", {25'h0, i_dev.gen(w)}, {25'h0, diag_chk});
		check_val("diag mode flags", 32'h2, {30'h0, diag_flg});
		check_val("diag syndrome", {25'h0, i_dev.gen(w ^ 32'h800) ^ i_dev.gen(w)}, {25'h0, rsp_check_o});
		give_verdict;
	end
endmodule // tb_top
